// *** pbp_pkg.sv ***
// Shared types and constants of the bus phase engine.
// Assumes one bus clock and synchronous pin sampling.
package pbp_pkg;

    localparam int AD_W   = 64;
    localparam int HALF_W = 32;
    localparam int CBE_W  = 8;
    localparam int LANES  = 2;

    // Commands that carry a byte address; others use a doubleword address
    localparam logic [3:0] CMD_IO_READ  = 4'h2;
    localparam logic [3:0] CMD_IO_WRITE = 4'h3;
    localparam logic [1:0] DWORD_LSBS   = 2'h0;

    // Output enables are active low; this is the floating value
    localparam logic OE_OFF = 1'b1;
    localparam logic OE_ON  = 1'b0;
    // Undriven control lines and idle byte enables park high
    localparam logic       LINE_HIGH = 1'b1;
    localparam logic [7:0] BE_NONE_N = 8'hff;
    localparam logic [63:0] AD_RESET = 64'h0;

    typedef struct packed {
        logic [63:0] addr;
        logic [7:0]  cmd_n;
        logic        write;
    } pbp_req_t;

    // Lane k of data holds byte k, qualified by byteEn_n[k]
    typedef struct packed {
        logic [63:0] data;
        logic [7:0]  byteEn_n;
        logic        last;
    } pbp_beat_t;

    typedef enum logic [3:0] {
        M_IDLE = 4'h1,
        M_ADDR = 4'h2,
        M_DATA = 4'h4,
        M_TURN = 4'h8
    } pbp_mst_t;

    typedef enum logic [2:0] {
        T_IDLE  = 3'h1,
        T_TURN  = 3'h2,
        T_DRIVE = 3'h4
    } pbp_tgt_t;

endpackage

// *** pbp_parity.sv ***
// Even parity over each 32-bit half and its four command/enable lines.
// Assumes its inputs are the sampled bus levels.
`timescale 1ns/1ps
module pbp_parity
    import pbp_pkg::*;
(
    input  wire logic [63:0] adBus,
    input  wire logic [7:0]  cbeBus_n,
    output logic      [1:0]  parity
);
    genvar lane;
    generate
        for (lane = 0; lane < LANES; lane++)
        begin : g_lane
            // Lane 0 covers AD[31:0]/CBE[3:0], lane 1 the upper half
            assign parity[lane] = ^{adBus[lane*HALF_W +: HALF_W],
                                    cbeBus_n[lane*4 +: 4]};
        end
    endgenerate
endmodule

// *** pbp_bus_phase.sv ***
// Address/data phase engine of a 64-bit parallel expansion bus port,
// acting as initiator and as read target.
// Assumes arbitration, target decode and the target-ready pin live outside.
//
// Overview of operation
// - Drive sustained lines high before floating.
// - Wait one idle clock before taking ownership.
// - Float all bus pins during bus reset.
// - Address phase is first cycle frame low.
// - Address phase carries byte or doubleword address.
// - Lane zero least, lane seven most significant.
// - Upper half idle on a 32-bit bus.
// - Command in address, byte enables in data.
// - Enable bit k qualifies byte lane k.
// - Lower parity even over low half, CBE3:0.
// - Upper parity even over high half, CBE7:4.
// - Address parity valid one clock later.
// - Data parity valid one clock, held after.
// - Parity driven for own address, write, read-target.
// - Master asserts frame while transfers continue.
// - Phase completes when both ready lines low.
// - Initiator ready: write data valid, read accept.
// - Drive initiator ready only as master.
`timescale 1ns/1ps
module pbp_bus_phase
    import pbp_pkg::*;
(
    input  wire logic              mclk,
    input  wire logic              rst_n,
    input  wire logic              bus64,
    input  wire logic              grant,
    input  wire logic              mReqValid,
    input  wire pbp_pkg::pbp_req_t  mReq,
    output logic                   mReqTaken,
    input  wire logic              mBeatValid,
    input  wire pbp_pkg::pbp_beat_t mBeat,
    output logic                   mBeatTaken,
    output logic      [63:0]       mRdData,
    output logic                   mRdValid,
    output logic                   mBusy,
    input  wire logic              tgtReadSel,
    input  wire logic [63:0]       tgtData,
    output logic                   tgtDataTaken,
    input  wire logic [63:0]       adIn,
    output logic      [63:0]       adOut,
    output logic      [1:0]        adOe_n,
    input  wire logic [7:0]        cbeIn_n,
    output logic      [7:0]        cbeOut_n,
    output logic      [1:0]        cbeOe_n,
    input  wire logic [1:0]        parIn,
    output logic      [1:0]        parOut,
    output logic      [1:0]        parOe_n,
    input  wire logic              frameIn_n,
    output logic                   frameOut_n,
    output logic                   frameOe_n,
    input  wire logic              irdyIn_n,
    output logic                   irdyOut_n,
    output logic                   irdyOe_n,
    input  wire logic              trdyIn_n
);
    import pbp_pkg::*;

    pbp_mst_t    mst_reg,       mstNext;
    pbp_tgt_t    tgt_reg,       tgtNext;
    logic [63:0] adOut_reg,     adNext;
    logic [7:0]  cbeOut_reg,    cbeNext;
    logic [1:0]  adOe_reg,      adOeNext;
    logic [1:0]  cbeOe_reg,     cbeOeNext;
    logic [1:0]  parOut_reg;
    logic [1:0]  parOe_reg;
    logic        frameOut_reg,  frameNext;
    logic        frameOe_reg,   frameOeNext;
    logic        irdyOut_reg,   irdyNext;
    logic        irdyOe_reg,    irdyOeNext;
    logic        last_reg,      lastNext;
    logic        isWrite_reg;
    logic        reqTaken_reg;
    logic        beatTaken_reg;
    logic [63:0] rdData_reg;
    logic        rdValid_reg;
    logic        tgtTaken_reg;
    logic        idleSeen_reg;
    logic        busy_reg;
    logic        framePrev_reg;
    logic        loadBeat;
    logic        loadTgt;
    logic [1:0]  busParity;

    // Decode of bus conditions
    wire        phaseDone  = ~irdyIn_n & ~trdyIn_n;
    wire        addrPhase  = ~frameIn_n & framePrev_reg;
    wire        busIdle    = frameIn_n & irdyIn_n & idleSeen_reg;
    // Command lines are active low; compare the true command code
    wire        isIoCmd    = (~mReq.cmd_n[3:0] == CMD_IO_READ) |
                             (~mReq.cmd_n[3:0] == CMD_IO_WRITE);
    wire [63:0] addrOut    = isIoCmd ? mReq.addr
                           : {mReq.addr[63:2], DWORD_LSBS};
    wire        startOk    = (mst_reg == M_IDLE) & (tgt_reg == T_IDLE) &
                             mReqValid & grant & busIdle & ~reqTaken_reg;
    // A beat is held off while its take pulse is still visible upstream
    wire        beatOk     = mBeatValid & ~beatTaken_reg;
    wire [1:0]  laneOn     = {~bus64, 1'b0};
    wire [1:0]  laneOe_n   = laneOn | {2{OE_OFF & 1'b0}};
    wire        mstOwnsAd  = (mst_reg != M_IDLE) | startOk;
    wire [63:0] rdCapture  = bus64 ? adIn : {32'h0, adIn[31:0]};

    pbp_parity u_parity
    (
        .adBus    (adIn),
        .cbeBus_n (cbeIn_n),
        .parity   (busParity)
    );

    // Initiator sequencing
    always_comb
    begin
        mstNext     = mst_reg;
        adNext      = adOut_reg;
        cbeNext     = cbeOut_reg;
        adOeNext    = {2{OE_OFF}};
        cbeOeNext   = {2{OE_OFF}};
        frameNext   = frameOut_reg;
        frameOeNext = frameOe_reg;
        irdyNext    = irdyOut_reg;
        irdyOeNext  = irdyOe_reg;
        lastNext    = last_reg;
        loadBeat    = 1'b0;
        case (mst_reg)
            M_IDLE:
            begin
                frameNext   = LINE_HIGH;
                frameOeNext = OE_OFF;
                irdyNext    = LINE_HIGH;
                irdyOeNext  = OE_OFF;
                if (startOk)
                begin
                    mstNext     = M_ADDR;
                    adNext      = addrOut;
                    cbeNext     = mReq.cmd_n;
                    adOeNext    = laneOe_n;
                    cbeOeNext   = laneOe_n;
                    frameNext   = 1'b0;
                    frameOeNext = OE_ON;
                    irdyOeNext  = OE_ON;
                    lastNext    = 1'b0;
                end
            end
            M_ADDR, M_DATA:
            begin
                mstNext   = M_DATA;
                cbeOeNext = laneOe_n;
                adOeNext  = (isWrite_reg ? laneOe_n : {2{OE_OFF}});
                if (mst_reg == M_ADDR)
                begin
                    // No beat yet: keep every lane disabled
                    cbeNext = BE_NONE_N;
                end
                if (mst_reg == M_DATA && phaseDone && last_reg)
                begin
                    mstNext   = M_TURN;
                    frameNext = LINE_HIGH;
                    irdyNext  = LINE_HIGH;
                    adOeNext  = {2{OE_OFF}};
                    cbeOeNext = {2{OE_OFF}};
                end
                else if ((irdyOut_reg | (mst_reg == M_DATA && phaseDone))
                         && beatOk && !last_reg)
                begin
                    loadBeat  = 1'b1;
                    adNext    = mBeat.data;
                    cbeNext   = mBeat.byteEn_n;
                    irdyNext  = 1'b0;
                    frameNext = mBeat.last;
                    lastNext  = mBeat.last;
                end
                else if (mst_reg == M_DATA && phaseDone)
                begin
                    irdyNext = LINE_HIGH;
                end
            end
            M_TURN:
            begin
                mstNext     = M_IDLE;
                frameOeNext = OE_OFF;
                irdyOeNext  = OE_OFF;
            end
            default:
            begin
                mstNext = M_IDLE;
            end
        endcase
    end

    // Read target data drive; the pin of target ready is driven elsewhere
    always_comb
    begin
        tgtNext = tgt_reg;
        loadTgt = 1'b0;
        case (tgt_reg)
            T_IDLE:
            begin
                if (tgtReadSel && mst_reg == M_IDLE && !startOk)
                begin
                    tgtNext = T_TURN;
                end
            end
            T_TURN:
            begin
                tgtNext = tgtReadSel ? T_DRIVE : T_IDLE;
                loadTgt = tgtReadSel;
            end
            T_DRIVE:
            begin
                if (!tgtReadSel || (phaseDone && frameIn_n))
                begin
                    tgtNext = T_IDLE;
                end
                else if (phaseDone)
                begin
                    loadTgt = 1'b1;
                end
            end
            default:
            begin
                tgtNext = T_IDLE;
            end
        endcase
    end

    wire        tgtDrives = (tgtNext == T_DRIVE);
    wire [63:0] adSel     = mstOwnsAd ? adNext
                          : (loadTgt ? tgtData : adOut_reg);
    wire [1:0]  adOeSel   = mstOwnsAd ? adOeNext
                          : (tgtDrives ? laneOe_n : {2{OE_OFF}});

    // All enables float under reset, no exception lives in this block
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mst_reg      <= M_IDLE;
            tgt_reg      <= T_IDLE;
            adOut_reg    <= AD_RESET;
            cbeOut_reg   <= BE_NONE_N;
            adOe_reg     <= {2{OE_OFF}};
            cbeOe_reg    <= {2{OE_OFF}};
            parOut_reg   <= 2'h0;
            parOe_reg    <= {2{OE_OFF}};
            frameOut_reg <= LINE_HIGH;
            frameOe_reg  <= OE_OFF;
            irdyOut_reg  <= LINE_HIGH;
            irdyOe_reg   <= OE_OFF;
            last_reg     <= 1'b0;
        end
        else
        begin
            mst_reg      <= mstNext;
            tgt_reg      <= tgtNext;
            adOut_reg    <= adSel;
            cbeOut_reg   <= cbeNext;
            adOe_reg     <= adOeSel;
            cbeOe_reg    <= cbeOeNext;
            parOut_reg   <= busParity;
            parOe_reg    <= adOe_reg | laneOn;
            frameOut_reg <= frameNext;
            frameOe_reg  <= frameOeNext;
            irdyOut_reg  <= irdyNext;
            irdyOe_reg   <= irdyOeNext;
            last_reg     <= lastNext;
        end
    end

    // Handshake pulses and bookkeeping
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            isWrite_reg   <= 1'b0;
            reqTaken_reg  <= 1'b0;
            beatTaken_reg <= 1'b0;
            rdData_reg    <= AD_RESET;
            rdValid_reg   <= 1'b0;
            tgtTaken_reg  <= 1'b0;
            idleSeen_reg  <= 1'b0;
            busy_reg      <= 1'b0;
            framePrev_reg <= LINE_HIGH;
        end
        else
        begin
            isWrite_reg   <= startOk ? mReq.write : isWrite_reg;
            reqTaken_reg  <= startOk;
            beatTaken_reg <= loadBeat;
            rdValid_reg   <= (mst_reg == M_DATA) & phaseDone & ~isWrite_reg;
            rdData_reg    <= ((mst_reg == M_DATA) & phaseDone & ~isWrite_reg)
                             ? rdCapture : rdData_reg;
            tgtTaken_reg  <= loadTgt;
            idleSeen_reg  <= frameIn_n & irdyIn_n;
            busy_reg      <= (mstNext != M_IDLE) | (tgtNext != T_IDLE);
            framePrev_reg <= frameIn_n;
        end
    end

    assign mReqTaken    = reqTaken_reg;
    assign mBeatTaken   = beatTaken_reg;
    assign mRdData      = rdData_reg;
    assign mRdValid     = rdValid_reg;
    assign mBusy        = busy_reg;
    assign tgtDataTaken = tgtTaken_reg;
    assign adOut        = adOut_reg;
    assign adOe_n       = adOe_reg;
    assign cbeOut_n     = cbeOut_reg;
    assign cbeOe_n      = cbeOe_reg;
    assign parOut       = parOut_reg;
    assign parOe_n      = parOe_reg;
    assign frameOut_n   = frameOut_reg;
    assign frameOe_n    = frameOe_reg;
    assign irdyOut_n    = irdyOut_reg;
    assign irdyOe_n     = irdyOe_reg;

    // Checks on the driven bus
    sequence s_parkHigh(logic oe_n, logic lvl);
        !oe_n && lvl;
    endsequence

    a_reset_float: assert property (@(posedge mclk)
        $rose(rst_n) |-> (&adOe_reg) && (&cbeOe_reg) && (&parOe_reg)
                         && frameOe_reg && irdyOe_reg)
        else $error("bus driven right after reset");

    a_frame_park_high: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $rose(frameOe_reg) |-> $past(!frameOe_reg && frameOut_reg))
        else $error("frame floated without high cycle");

    a_irdy_park_high: assert property (@(posedge mclk)
        disable iff (!rst_n)
        s_parkHigh(irdyOe_reg, irdyOut_reg) ##1 irdyOe_reg
        |-> $past(mst_reg) == M_TURN)
        else $error("initiator ready released out of turnaround");

    a_turn_gap: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $fell(frameOe_reg) |-> $past(frameIn_n) && $past(frameIn_n, 2))
        else $error("frame driven with no idle clock");

    a_addr_parity: assert property (@(posedge mclk)
        disable iff (!rst_n)
        mst_reg == M_ADDR |=> !parOe_reg[0] &&
            parOut_reg[0] == ^{$past(adOut_reg[31:0]),
                               $past(cbeOut_reg[3:0])})
        else $error("address parity wrong or late");

    a_data_parity: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !adOe_reg[0] |=> !parOe_reg[0] &&
            parOut_reg[0] == ^{$past(adIn[31:0]), $past(cbeIn_n[3:0])})
        else $error("data parity not one clock behind");

    a_upper_idle: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !bus64 && $past(!bus64, 2) |-> adOe_reg[1] && cbeOe_reg[1]
                                        && parOe_reg[1])
        else $error("upper half driven on narrow bus");

    a_last_phase: assert property (@(posedge mclk)
        disable iff (!rst_n)
        $rose(frameOut_reg) && !frameOe_reg && mst_reg == M_DATA
        |-> !irdyOut_reg)
        else $error("frame released without initiator ready");

    a_irdy_hold: assert property (@(posedge mclk)
        disable iff (!rst_n)
        !irdyOe_reg && !irdyOut_reg && trdyIn_n |=> !irdyOut_reg)
        else $error("initiator ready dropped before completion");

    a_read_no_par: assert property (@(posedge mclk)
        disable iff (!rst_n)
        mst_reg == M_DATA && $past(mst_reg) == M_DATA && !isWrite_reg
        |-> &parOe_reg)
        else $error("parity driven on master read data");

    a_target_irdy: assert property (@(posedge mclk)
        disable iff (!rst_n)
        tgt_reg != T_IDLE |-> irdyOe_reg)
        else $error("initiator ready driven as target");

    a_frame_start: assert property (@(posedge mclk)
        disable iff (!rst_n)
        mst_reg == M_ADDR |-> !frameOut_reg && !frameOe_reg
                              && $past(frameOe_reg))
        else $error("address phase without frame");

    a_addr_dword: assert property (@(posedge mclk)
        disable iff (!rst_n)
        mst_reg == M_ADDR && cbeOut_reg[3:1] != 3'h6
        |-> adOut_reg[1:0] == DWORD_LSBS)
        else $error("doubleword address has low bits set");

    a_addr_seen: assert property (@(posedge mclk)
        disable iff (!rst_n)
        mst_reg == M_ADDR |-> addrPhase ##1 !addrPhase)
        else $error("address phase detection out of step");
endmodule

// *** pbp_host_model.sv ***
// Far side of the bus: wire resolution, target ready, a host initiator.
// Assumes design pins come as out/oe_n pairs, oe_n low while driving.
`timescale 1ns/1ps
module pbp_host_model
    import pbp_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic [63:0] adOut,
    input  wire logic [1:0]  adOe_n,
    input  wire logic [7:0]  cbeOut_n,
    input  wire logic [1:0]  cbeOe_n,
    input  wire logic        frameOut_n,
    input  wire logic        frameOe_n,
    input  wire logic        irdyOut_n,
    input  wire logic        irdyOe_n,
    input  wire logic [3:0]  trdyWait,
    input  wire logic        hostGo,
    input  wire logic [63:0] hostAd,
    input  wire logic [63:0] rdWord,
    output logic      [63:0] adIn,
    output logic      [7:0]  cbeIn_n,
    output logic             frameIn_n,
    output logic             irdyIn_n,
    output logic             trdyIn_n
);
    import pbp_pkg::*;
    logic [63:0] adLast;
    logic [7:0]  cbeLast;
    logic [3:0]  waitCnt;
    logic [1:0]  hostSt;
    logic        frameLast, trdyDrv, trdyRel, readCyc;
    wire         addrPh = !frameIn_n && frameLast;
    wire         done   = !irdyIn_n && !trdyIn_n;
    wire         trdyLo = trdyDrv && !trdyRel && waitCnt == 4'h0;
    wire         adDrv  = readCyc && trdyLo;
    // Host reads are single beat, so frame is high in its data phase
    assign frameIn_n = (frameOe_n == OE_ON) ? frameOut_n :
                       (hostSt != 2'h1);
    assign irdyIn_n  = (irdyOe_n == OE_ON) ? irdyOut_n :
                       (hostSt != 2'h2);
    assign trdyIn_n  = !trdyLo;
    always_comb
    begin
        // No pull-up here: a floating wire shows its last level inverted
        adIn = ~adLast;
        cbeIn_n = ~cbeLast;
        if (hostSt == 2'h1)
            adIn = hostAd;
        if (hostSt == 2'h1)
            cbeIn_n = 8'hf9;
        if (hostSt == 2'h2)
            cbeIn_n = 8'h00;
        if (adDrv)
            adIn = rdWord;
        if (adOe_n[0] == OE_ON)
            adIn[31:0] = adOut[31:0];
        if (adOe_n[1] == OE_ON)
            adIn[63:32] = adOut[63:32];
        if (cbeOe_n[0] == OE_ON)
            cbeIn_n[3:0] = cbeOut_n[3:0];
        if (cbeOe_n[1] == OE_ON)
            cbeIn_n[7:4] = cbeOut_n[7:4];
    end
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            adLast <= '0;
            cbeLast <= '0;
            waitCnt <= 4'h0;
            hostSt <= 2'h0;
            frameLast <= 1'b1;
            trdyDrv <= 1'b0;
            trdyRel <= 1'b0;
            readCyc <= 1'b0;
        end
        else
        begin
            adLast <= adIn;
            cbeLast <= cbeIn_n;
            frameLast <= frameIn_n;
            trdyRel <= trdyLo && done && frameIn_n;
            if (trdyRel)
                trdyDrv <= 1'b0;
            if (waitCnt != 4'h0)
                waitCnt <= waitCnt - 4'h1;
            if (done && !frameIn_n)
                waitCnt <= trdyWait;
            if (addrPh)
            begin
                trdyDrv <= 1'b1;
                waitCnt <= trdyWait;
                readCyc <= cbeIn_n[0] && hostSt == 2'h0;
            end
            if (hostSt != 2'h0 && (hostSt != 2'h2 || done))
                hostSt <= hostSt + 2'h1;
            if (hostGo && hostSt == 2'h0)
                hostSt <= 2'h1;
        end
    end
endmodule

// *** pbp_bus_phase_test.sv ***
// Self-checking bench of the bus phase engine.
// Assumes the host model resolves every shared wire except parity, which loops parOut straight back to parIn.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin failures++; \
    $display("wrong value at %0t got %h expected %h", $time, (g), (e)); \
    end end
module pbp_bus_phase_test;
    import pbp_pkg::*;
    logic        mclk, rst_n, bus64, grant, mReqValid, mBeatValid, hostGo;
    logic        tgtReadSel, mReqTaken, mBeatTaken, mRdValid, mBusy;
    logic        tgtDataTaken, frameIn_n, frameOut_n, frameOe_n, trdyIn_n;
    logic        irdyIn_n, irdyOut_n, irdyOe_n, frPrev, frOe, irPrev, irOe;
    logic [1:0]  adOe_n, cbeOe_n, parOut, parOe_n;
    logic [3:0]  trdyWait;
    logic [7:0]  cbeIn_n, cbeOut_n;
    logic [63:0] mRdData, tgtData, adIn, adOut, hostAd, rdWord;
    pbp_req_t    mReq;
    pbp_beat_t   mBeat;
    int          failures, check_count, cycles;

    pbp_bus_phase u_pbp_bus_phase (.mclk, .rst_n, .bus64, .grant, .mReqValid,
        .mReq, .mReqTaken, .mBeatValid, .mBeat, .mBeatTaken, .mRdData,
        .mRdValid, .mBusy, .tgtReadSel, .tgtData, .tgtDataTaken, .adIn,
        .adOut, .adOe_n, .cbeIn_n, .cbeOut_n, .cbeOe_n, .parIn(parOut),
        .parOut, .parOe_n, .frameIn_n, .frameOut_n, .frameOe_n, .irdyIn_n,
        .irdyOut_n, .irdyOe_n, .trdyIn_n);
    pbp_host_model u_pbp_host_model (.mclk, .rst_n, .adOut, .adOe_n,
        .cbeOut_n, .cbeOe_n, .frameOut_n, .frameOe_n, .irdyOut_n, .irdyOe_n,
        .trdyWait, .hostGo, .hostAd, .rdWord, .adIn, .cbeIn_n, .frameIn_n,
        .irdyIn_n, .trdyIn_n);

    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    task automatic final_report();
        if (failures == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // Whole run needs about a hundred cycles
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            failures++;
            final_report();
        end
    end

    always @(posedge mclk)
    begin
        #1;
        if (rst_n && frOe == OE_ON && frameOe_n == OE_OFF)
            `CHK(frPrev, LINE_HIGH)
        if (rst_n && irOe == OE_ON && irdyOe_n == OE_OFF)
            `CHK(irPrev, LINE_HIGH)
        frPrev = frameOut_n;
        frOe = frameOe_n;
        irPrev = irdyOut_n;
        irOe = irdyOe_n;
    end

    function automatic pbp_beat_t beat(int k, int nb);
        beat.data = 64'h8706_0504_0302_0100 + 64'h1111_1111_1111_1111 * 64'(k);
        beat.byteEn_n = k[0] ? 8'h5a : 8'h00;
        beat.last = (k == nb - 1);
    endfunction

    task automatic checkOff();
        `CHK({adOe_n, cbeOe_n, parOe_n, frameOe_n, irdyOe_n}, 8'hff)
    endtask

    task automatic mXfer(input logic b, input logic wr, input logic [3:0] cmd,
                         input int nb, input logic [3:0] w);
        logic [63:0] ea;
        logic [7:0]  cn;
        logic [1:0]  p;
        pbp_beat_t   e;
        int          k, fed;
        logic        pend, tk;
        cn = {4'hf, ~cmd};
        ea = 64'h1234_5678_9abc_def3;
        if (cmd != CMD_IO_READ && cmd != CMD_IO_WRITE)
            ea[1:0] = DWORD_LSBS;
        p = {^{ea[63:32], cn[7:4]}, ^{ea[31:0], cn[3:0]}};
        @(posedge mclk);
        bus64 <= b;
        trdyWait <= w;
        grant <= 1'b0;
        mReqValid <= 1'b1;
        mReq <= '{64'h1234_5678_9abc_def3, cn, wr};
        mBeatValid <= 1'b1;
        mBeat <= beat(0, nb);
        repeat (3) @(posedge mclk);
        #1;
        `CHK(frameOe_n, OE_OFF)
        @(posedge mclk);
        grant <= 1'b1;
        repeat (20)
        begin
            @(posedge mclk);
            #1;
            if (mReqTaken === 1'b1)
                break;
        end
        `CHK(frameIn_n, 1'b0)
        `CHK(adIn[31:0], ea[31:0])
        `CHK(cbeIn_n[3:0], cn[3:0])
        `CHK(adOe_n[1], b ? OE_ON : OE_OFF)
        if (b)
            `CHK(adIn[63:32], ea[63:32])
        @(posedge mclk);
        mReqValid <= 1'b0;
        #1;
        `CHK(parOut[0], p[0])
        `CHK(parOe_n, b ? {OE_ON, OE_ON} : {OE_OFF, OE_ON})
        if (b)
            `CHK(parOut[1], p[1])
        k = 0;
        fed = 0;
        pend = 0;
        repeat (60)
        begin
            if (pend && wr)
                `CHK(parOut[0], ^{e.data[31:0], e.byteEn_n[3:0]})
            if (pend && wr && b)
                `CHK(parOut[1], ^{e.data[63:32], e.byteEn_n[7:4]})
            if (pend && !wr)
                `CHK({mRdValid, parOe_n}, 3'h7)
            if (pend && !wr)
                `CHK(mRdData, b ? rdWord : {32'h0, rdWord[31:0]})
            pend = 0;
            e = beat(k, nb);
            if (!b)
                `CHK({adOe_n[1], cbeOe_n[1]}, 2'h3)
            if (irdyIn_n === 1'b0 && k < nb)
            begin
                `CHK(cbeIn_n[3:0], e.byteEn_n[3:0])
                if (b)
                    `CHK(cbeIn_n[7:4], e.byteEn_n[7:4])
                if (wr)
                    `CHK(adIn[31:0], e.data[31:0])
                if (wr && b)
                    `CHK(adIn[63:32], e.data[63:32])
                if (!wr)
                    `CHK(adOe_n, 2'h3)
                if (trdyIn_n === 1'b0)
                begin
                    `CHK(frameIn_n, e.last)
                    pend = 1;
                    k++;
                end
            end
            if (k == nb && !pend)
                break;
            tk = (mBeatTaken === 1'b1);
            @(posedge mclk);
            if (tk)
                fed++;
            if (tk)
                mBeat <= beat(fed, nb);
            if (tk)
                mBeatValid <= (fed < nb);
            #1;
        end
        `CHK(k, nb)
        @(posedge mclk);
        #1;
        `CHK({mBusy, frameOe_n, adOe_n}, 4'h7)
    endtask

    task automatic tRead();
        logic [63:0] t;
        t = 64'h0f1e_2d3c_4b5a_6978;
        @(posedge mclk);
        bus64 <= 1'b1;
        trdyWait <= 4'h2;
        tgtData <= t;
        hostGo <= 1'b1;
        @(posedge mclk);
        hostGo <= 1'b0;
        #1;
        `CHK(frameIn_n, 1'b0)
        @(posedge mclk);
        tgtReadSel <= 1'b1;
        #1;
        `CHK(adOe_n, 2'h3)
        @(posedge mclk);
        #1;
        `CHK({adOe_n, irdyOe_n}, 3'h7)
        @(posedge mclk);
        #1;
        `CHK(adIn, t)
        `CHK({trdyIn_n, irdyIn_n, tgtDataTaken}, 3'h1)
        @(posedge mclk);
        tgtReadSel <= 1'b0;
        #1;
        `CHK(parOut, {^t[63:32], ^t[31:0]})
        `CHK({parOe_n, irdyOe_n}, 3'h1)
        @(posedge mclk);
        #1;
        `CHK(adOe_n, 2'h3)
    endtask

    task automatic midReset();
        @(posedge mclk);
        mReqValid <= 1'b1;
        repeat (20)
        begin
            @(posedge mclk);
            #1;
            if (mReqTaken === 1'b1)
                break;
        end
        `CHK(frameOe_n, OE_ON)
        @(posedge mclk);
        rst_n <= 1'b0;
        mReqValid <= 1'b0;
        #1;
        checkOff();
        repeat (3) @(posedge mclk);
        rst_n <= 1'b1;
        #1;
        checkOff();
        repeat (2) @(posedge mclk);
    endtask

    initial
    begin
        rst_n = 1'b0;
        bus64 = 1'b1;
        grant = 1'b0;
        mReqValid = 1'b0;
        mReq = '0;
        mBeatValid = 1'b0;
        mBeat = '0;
        tgtReadSel = 1'b0;
        tgtData = '0;
        hostGo = 1'b0;
        hostAd = 64'h0000_0001_0000_0100;
        rdWord = 64'hfedc_ba98_7654_3210;
        trdyWait = 4'h0;
        failures = 0;
        check_count = 0;
        cycles = 0;
        @(posedge mclk);
        #1;
        checkOff();
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (2) @(posedge mclk);
        mXfer(1'b1, 1'b1, 4'h7, 1, 4'h0);
        mXfer(1'b1, 1'b1, 4'h7, 3, 4'h2);
        mXfer(1'b0, 1'b1, CMD_IO_WRITE, 2, 4'h1);
        mXfer(1'b1, 1'b0, CMD_IO_READ, 1, 4'h1);
        mXfer(1'b0, 1'b0, 4'h6, 1, 4'h3);
        tRead();
        midReset();
        mXfer(1'b1, 1'b1, 4'h7, 2, 4'h0);
        final_report();
    end
endmodule
